/* File: core/ssl_sensor.sv */
// Sensor end of the single-wire addressed link
// Overview of operation
// - 1200 baud, start, 7 data LSB first, even parity, stop
// - Logical one sent as low line level
// - Send startup string during power-up unless suppressed
// - Logger waits out power-up before commanding
// - Accept commands except continuous measurement ones
// - Factory address 0, startup string enabled
// - Skip startup if address nonzero or suppressed
// - Integrator should pick nonzero address
// - Startup mode: transmit only, measure on power
// - Bus mode: measure only on received command
// - Logger gives each sensor a distinct address
// - Compromised measurement reports -9999
// - Bad calibration reports -9992
// - Low supply reports -9991
// - Out of range reports -9990
// - Frames start with address, end CR LF
// - Identify: address then 13
// - Then 8-char vendor, 6-char model
// - Then 3-digit version
// - Then optional serial up to 13 chars
// - Power-up done within 200 ms
`timescale 1ns/1ps
`default_nettype none
module ssl_sensor #(
  parameter int POWERUP_CYCLES = ssl_pkg::POWERUP_CYCLES,
  parameter int BIT_CYCLES = ssl_pkg::BIT_CYCLES,
  parameter logic [6:0] ADDRESS = ssl_pkg::CH_ZERO,
  parameter logic [8*7-1:0] VENDOR = {8{7'h41}},
  parameter logic [6*7-1:0] MODEL = {6{7'h42}},
  parameter logic [3*7-1:0] VERSION = {7'h31, 7'h30, 7'h30},
  parameter logic [13*7-1:0] SERIAL = {13{7'h58}},
  parameter int SERIAL_LEN = 4
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  ssl_if.sensor link,
  input wire logic suppress_in,
  input wire logic meas_valid_in,
  input wire logic [6:0] meas_digits_in [5],
  input wire logic meas_negative_in,
  input wire logic [1:0] meas_error_in,
  input wire logic meas_out_of_range_in,
  output logic meas_start_out,
  output logic ready_out,
  output logic busy_out
);
  typedef enum logic [3:0] {
    SSL_POWERUP = 4'b0001,
    SSL_LISTEN = 4'b0010,
    SSL_WAIT_MEAS = 4'b0100,
    SSL_SEND = 4'b1000
  } ssl_state_e;

  localparam int ID_LEN = 3 + ssl_pkg::VENDOR_LEN + ssl_pkg::MODEL_LEN
    + ssl_pkg::VERSION_LEN + SERIAL_LEN + 2;
  localparam int VAL_LEN = 1 + 1 + ssl_pkg::VALUE_LEN + 2;
  localparam int ACK_LEN = 3;

  ssl_state_e state_reg;
  logic [31:0] pwr_cnt_reg;
  logic [15:0] baud_cnt_reg;
  logic [3:0] bit_idx_reg;
  logic [9:0] shift_reg;
  logic [5:0] ch_idx_reg;
  logic [5:0] ch_len_reg;
  logic [6:0] resp_reg [ssl_pkg::RESP_MAX];
  logic startup_pending_reg;
  logic rx_meta_reg;
  logic rx_sync_reg;
  logic rx_busy_reg;
  logic [15:0] rx_cnt_reg;
  logic [3:0] rx_bit_reg;
  logic [8:0] rx_sh_reg;
  logic [6:0] cmd_reg [ssl_pkg::CMD_MAX];
  logic [3:0] cmd_len_reg;
  logic sensor_out_reg;
  logic sensor_oe_reg;
  logic meas_start_reg;
  logic id_cmd_reg;

  // Line high means logical zero; bit value is inverted line
  wire rx_bit = ~rx_sync_reg;
  wire rx_start = ~rx_busy_reg & rx_sync_reg;
  wire baud_cnt_zero_rx = rx_cnt_reg == 16'h0;
  // Stop bit is the ninth sample, still unshifted here
  wire rx_done = rx_busy_reg && baud_cnt_zero_rx && rx_bit_reg == 4'(ssl_pkg::DATA_BITS + 1);
  wire [6:0] rx_char = rx_sh_reg[7:1];
  wire rx_par_ok = ^rx_sh_reg[8:1] == 1'b0;
  wire startup_en = (ADDRESS == ssl_pkg::CH_ZERO) && !suppress_in;
  wire addr_hit = cmd_reg[0] == ADDRESS || cmd_reg[0] == ssl_pkg::CH_WILD;
  wire cmd_end = rx_done && rx_par_ok && rx_char == ssl_pkg::CH_BANG;
  wire is_id = cmd_len_reg == 4'h2 && cmd_reg[1] == ssl_pkg::CH_ID;
  wire is_cont = cmd_reg[1] == ssl_pkg::CH_CMD_R
    || (cmd_reg[1] == ssl_pkg::CH_CMD_C && cmd_reg[2] == ssl_pkg::CH_CMD_R);
  wire tx_bit_end = baud_cnt_reg == 16'h0;
  wire [6:0] tx_char = resp_reg[ch_idx_reg];
  wire [6:0] err_digit = meas_out_of_range_in ? ssl_pkg::ERR_DIGIT_RANGE
    : meas_error_in == ssl_pkg::ERR_FUNC ? ssl_pkg::ERR_DIGIT_FUNC
    : meas_error_in == ssl_pkg::ERR_CAL ? ssl_pkg::ERR_DIGIT_CAL
    : ssl_pkg::ERR_DIGIT_VOLT;
  wire meas_err = meas_out_of_range_in || meas_error_in != ssl_pkg::ERR_NONE;

  assign link.sensor_out = sensor_out_reg;
  assign link.sensor_oe = sensor_oe_reg;
  assign meas_start_out = meas_start_reg;
  assign busy_out = sensor_oe_reg;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_meta_reg <= 1'b0;
      rx_sync_reg <= 1'b0;
    end else begin
      rx_meta_reg <= link.line;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // Receiver, active only in the listen state
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_busy_reg <= 1'b0;
      rx_cnt_reg <= 16'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 9'h0;
    end else if (state_reg != SSL_LISTEN) begin
      rx_busy_reg <= 1'b0;
    end else if (rx_start) begin
      rx_busy_reg <= 1'b1;
      rx_cnt_reg <= 16'(BIT_CYCLES + BIT_CYCLES / 2);
      rx_bit_reg <= 4'h0;
    end else if (rx_busy_reg) begin
      if (baud_cnt_zero_rx) begin
        rx_sh_reg <= {rx_bit, rx_sh_reg[8:1]};
        rx_bit_reg <= rx_bit_reg + 4'h1;
        rx_cnt_reg <= 16'(BIT_CYCLES - 1);
        if (rx_bit_reg == 4'(ssl_pkg::DATA_BITS + 1)) begin
          rx_busy_reg <= 1'b0;
        end
      end else begin
        rx_cnt_reg <= rx_cnt_reg - 16'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= SSL_POWERUP;
      pwr_cnt_reg <= 32'h0;
      startup_pending_reg <= 1'b0;
      cmd_len_reg <= 4'h0;
      for (int i = 0; i < ssl_pkg::CMD_MAX; i++) begin
        cmd_reg[i] <= 7'h0;
      end
      for (int i = 0; i < ssl_pkg::RESP_MAX; i++) begin
        resp_reg[i] <= 7'h0;
      end
      ch_idx_reg <= 6'h0;
      ch_len_reg <= 6'h0;
      bit_idx_reg <= 4'h0;
      shift_reg <= 10'h0;
      baud_cnt_reg <= 16'h0;
      sensor_out_reg <= 1'b0;
      sensor_oe_reg <= 1'b0;
      meas_start_reg <= 1'b0;
      id_cmd_reg <= 1'b0;
      ready_out <= 1'b0;
    end else begin
      meas_start_reg <= 1'b0;
      // Power-up time runs on through the startup string
      if (pwr_cnt_reg < 32'(POWERUP_CYCLES)) begin
        pwr_cnt_reg <= pwr_cnt_reg + 32'h1;
      end
      unique case (state_reg)
        SSL_POWERUP: begin
          if (pwr_cnt_reg == 32'h0) begin
            startup_pending_reg <= startup_en;
            meas_start_reg <= startup_en;
          end
          if (startup_pending_reg) begin
            startup_pending_reg <= 1'b0;
            id_cmd_reg <= 1'b0;
            state_reg <= SSL_WAIT_MEAS;
          end else if (pwr_cnt_reg >= 32'(POWERUP_CYCLES - 1)) begin
            state_reg <= SSL_LISTEN;
            ready_out <= 1'b1;
            startup_pending_reg <= 1'b0;
          end
        end
        SSL_LISTEN: begin
          sensor_oe_reg <= 1'b0;
          ready_out <= 1'b1;
          if (rx_done && rx_par_ok) begin
            if (cmd_end) begin
              cmd_len_reg <= 4'h0;
              if (addr_hit && !is_cont) begin
                id_cmd_reg <= is_id;
                if (!is_id) begin
                  meas_start_reg <= 1'b1;
                end
                state_reg <= SSL_WAIT_MEAS;
              end
            end else if (cmd_len_reg < 4'(ssl_pkg::CMD_MAX)) begin
              cmd_reg[cmd_len_reg[2:0]] <= rx_char;
              cmd_len_reg <= cmd_len_reg + 4'h1;
            end
          end
        end
        SSL_WAIT_MEAS: begin
          if (id_cmd_reg || meas_valid_in) begin
            resp_reg[0] <= ADDRESS;
            ch_idx_reg <= 6'h0;
            // One bit of hold-off lets the logger's stop bit end first
            baud_cnt_reg <= 16'(BIT_CYCLES - 1);
            bit_idx_reg <= 4'(ssl_pkg::FRAME_BITS);
            state_reg <= SSL_SEND;
            if (id_cmd_reg) begin
              resp_reg[1] <= ssl_pkg::CH_ONE;
              resp_reg[2] <= ssl_pkg::CH_THREE;
              for (int i = 0; i < ssl_pkg::VENDOR_LEN; i++) begin
                resp_reg[3 + i] <= VENDOR[(7 - i) * 7 +: 7];
              end
              for (int i = 0; i < ssl_pkg::MODEL_LEN; i++) begin
                resp_reg[11 + i] <= MODEL[(5 - i) * 7 +: 7];
              end
              for (int i = 0; i < ssl_pkg::VERSION_LEN; i++) begin
                resp_reg[17 + i] <= VERSION[(2 - i) * 7 +: 7];
              end
              for (int i = 0; i < SERIAL_LEN; i++) begin
                resp_reg[20 + i] <= SERIAL[(12 - i) * 7 +: 7];
              end
              resp_reg[20 + SERIAL_LEN] <= ssl_pkg::CH_CR;
              resp_reg[21 + SERIAL_LEN] <= ssl_pkg::CH_LF;
              ch_len_reg <= 6'(ID_LEN - 1);
            end else begin
              resp_reg[1] <= (meas_err || meas_negative_in) ? ssl_pkg::CH_MINUS
                : ssl_pkg::CH_PLUS;
              for (int i = 0; i < ssl_pkg::VALUE_LEN; i++) begin
                resp_reg[2 + i] <= meas_err ? (i == 4 ? err_digit
                  : (i == 0 ? ssl_pkg::CH_ZERO : ssl_pkg::CH_NINE))
                  : meas_digits_in[i];
              end
              resp_reg[7] <= ssl_pkg::CH_CR;
              resp_reg[8] <= ssl_pkg::CH_LF;
              ch_len_reg <= 6'(VAL_LEN - 1);
            end
          end
        end
        SSL_SEND: begin
          if (tx_bit_end) begin
            baud_cnt_reg <= 16'(BIT_CYCLES - 1);
            if (bit_idx_reg == 4'(ssl_pkg::FRAME_BITS)) begin
              // Frame: start=0, data LSB first, even parity, stop=1
              shift_reg <= {1'b1, ^tx_char, tx_char, 1'b0};
              bit_idx_reg <= 4'h1;
              sensor_out_reg <= 1'b1;
              sensor_oe_reg <= 1'b1;
            end else begin
              sensor_out_reg <= ~shift_reg[bit_idx_reg];
              bit_idx_reg <= bit_idx_reg + 4'h1;
              if (bit_idx_reg == 4'(ssl_pkg::FRAME_BITS - 1)) begin
                if (ch_idx_reg == ch_len_reg) begin
                  bit_idx_reg <= 4'hf;
                end else begin
                  ch_idx_reg <= ch_idx_reg + 6'h1;
                end
              end
              if (bit_idx_reg == 4'hf) begin
                sensor_oe_reg <= 1'b0;
                sensor_out_reg <= 1'b0;
                state_reg <= (pwr_cnt_reg >= 32'(POWERUP_CYCLES - 1))
                  ? SSL_LISTEN : SSL_POWERUP;
              end
            end
          end else begin
            baud_cnt_reg <= baud_cnt_reg - 16'h1;
          end
        end
      endcase
    end
  end
endmodule : ssl_sensor
`default_nettype wire

/* File: include/ssl_pkg.sv */
// Shared constants for the single-wire sensor link
package ssl_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int BAUD = 1200;
  localparam int BIT_CYCLES = CLK_HZ / BAUD;
  localparam int HALF_CYCLES = BIT_CYCLES / 2;
  localparam int DATA_BITS = 7;
  localparam int FRAME_BITS = 10;
  localparam int POWERUP_MAX_MS = 200;
  localparam int POWERUP_TYP_MS = 175;
  localparam int POWERUP_CYCLES = (CLK_HZ / 1000) * POWERUP_MAX_MS;
  localparam logic [6:0] CH_CR = 7'h0d;
  localparam logic [6:0] CH_LF = 7'h0a;
  localparam logic [6:0] CH_BANG = 7'h21;
  localparam logic [6:0] CH_WILD = 7'h3f;
  localparam logic [6:0] CH_ZERO = 7'h30;
  localparam logic [6:0] CH_ONE = 7'h31;
  localparam logic [6:0] CH_THREE = 7'h33;
  localparam logic [6:0] CH_SPACE = 7'h20;
  localparam logic [6:0] CH_MINUS = 7'h2d;
  localparam logic [6:0] CH_PLUS = 7'h2b;
  localparam logic [6:0] CH_NINE = 7'h39;
  localparam logic [6:0] CH_ID = 7'h49;
  localparam logic [6:0] CH_CMD_R = 7'h52;
  localparam logic [6:0] CH_CMD_C = 7'h43;
  localparam int VENDOR_LEN = 8;
  localparam int MODEL_LEN = 6;
  localparam int VERSION_LEN = 3;
  localparam int SERIAL_MAX = 13;
  localparam int VALUE_LEN = 5;
  localparam int CMD_MAX = 8;
  localparam int RESP_MAX = 40;
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_FUNC = 2'h1;
  localparam logic [1:0] ERR_CAL = 2'h2;
  localparam logic [1:0] ERR_VOLT = 2'h3;
  localparam logic [6:0] ERR_DIGIT_FUNC = 7'h39;
  localparam logic [6:0] ERR_DIGIT_CAL = 7'h32;
  localparam logic [6:0] ERR_DIGIT_VOLT = 7'h31;
  localparam logic [6:0] ERR_DIGIT_RANGE = 7'h30;
endpackage : ssl_pkg

/* File: include/ssl_if.sv */
// Shared data wire between sensor and logger
`timescale 1ns/1ps
`default_nettype none
interface ssl_if;
  logic sensor_out;
  logic sensor_oe;
  logic logger_out;
  logic logger_oe;
  logic line;
  // Idle line is low (marking); driven value wins, sensor over logger
  assign line = sensor_oe ? sensor_out : (logger_oe ? logger_out : 1'b0);
  modport sensor (output sensor_out, output sensor_oe, input line);
  modport logger (output logger_out, output logger_oe, input line);
endinterface : ssl_if
`default_nettype wire

/* File: core/ssl_logger.sv */
// Logger end: sends commands, collects response characters
`timescale 1ns/1ps
`default_nettype none
module ssl_logger #(
  parameter int POWERUP_CYCLES = ssl_pkg::POWERUP_CYCLES,
  parameter int BIT_CYCLES = ssl_pkg::BIT_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  ssl_if.logger link,
  input wire logic cmd_valid_in,
  input wire logic [6:0] cmd_char_in,
  output logic cmd_ready_out,
  output logic rx_valid_out,
  output logic [6:0] rx_char_out,
  output logic rx_parity_err_out
);
  logic [31:0] pwr_cnt_reg;
  logic [15:0] tx_cnt_reg;
  logic [3:0] tx_bit_reg;
  logic [9:0] tx_sh_reg;
  logic tx_busy_reg;
  logic out_reg;
  logic oe_reg;
  logic meta_reg;
  logic sync_reg;
  logic rx_busy_reg;
  logic [15:0] rx_cnt_reg;
  logic [3:0] rx_bit_reg;
  logic [8:0] rx_sh_reg;

  // Commands held until sensor power-up has elapsed
  wire pwr_done = pwr_cnt_reg >= 32'(POWERUP_CYCLES);
  wire take = cmd_valid_in && cmd_ready_out;
  // Stop bit is the ninth sample, still unshifted here
  wire rx_last = rx_busy_reg && rx_cnt_reg == 16'h0
    && rx_bit_reg == 4'(ssl_pkg::DATA_BITS + 1);

  assign link.logger_out = out_reg;
  assign link.logger_oe = oe_reg;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= link.line;
      sync_reg <= meta_reg;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pwr_cnt_reg <= 32'h0;
      tx_busy_reg <= 1'b0;
      tx_cnt_reg <= 16'h0;
      tx_bit_reg <= 4'h0;
      tx_sh_reg <= 10'h0;
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
      cmd_ready_out <= 1'b0;
    end else begin
      if (!pwr_done) begin
        pwr_cnt_reg <= pwr_cnt_reg + 32'h1;
      end
      cmd_ready_out <= pwr_done && !tx_busy_reg && !take && !rx_busy_reg;
      if (take) begin
        tx_busy_reg <= 1'b1;
        tx_sh_reg <= {1'b1, ^cmd_char_in, cmd_char_in, 1'b0};
        tx_bit_reg <= 4'h0;
        tx_cnt_reg <= 16'h0;
      end else if (tx_busy_reg) begin
        if (tx_cnt_reg == 16'h0) begin
          tx_cnt_reg <= 16'(BIT_CYCLES - 1);
          if (tx_bit_reg == 4'(ssl_pkg::FRAME_BITS)) begin
            tx_busy_reg <= 1'b0;
            oe_reg <= 1'b0;
            out_reg <= 1'b0;
          end else begin
            out_reg <= ~tx_sh_reg[tx_bit_reg];
            oe_reg <= 1'b1;
            tx_bit_reg <= tx_bit_reg + 4'h1;
          end
        end else begin
          tx_cnt_reg <= tx_cnt_reg - 16'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_busy_reg <= 1'b0;
      rx_cnt_reg <= 16'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 9'h0;
      rx_valid_out <= 1'b0;
      rx_char_out <= 7'h0;
      rx_parity_err_out <= 1'b0;
    end else begin
      rx_valid_out <= 1'b0;
      if (tx_busy_reg) begin
        rx_busy_reg <= 1'b0;
      end else if (!rx_busy_reg && sync_reg) begin
        rx_busy_reg <= 1'b1;
        rx_cnt_reg <= 16'(BIT_CYCLES + BIT_CYCLES / 2);
        rx_bit_reg <= 4'h0;
      end else if (rx_busy_reg) begin
        if (rx_cnt_reg == 16'h0) begin
          rx_sh_reg <= {~sync_reg, rx_sh_reg[8:1]};
          rx_bit_reg <= rx_bit_reg + 4'h1;
          rx_cnt_reg <= 16'(BIT_CYCLES - 1);
          if (rx_last) begin
            rx_busy_reg <= 1'b0;
            rx_valid_out <= 1'b1;
            rx_char_out <= rx_sh_reg[7:1];
            rx_parity_err_out <= ^rx_sh_reg[8:1];
          end
        end else begin
          rx_cnt_reg <= rx_cnt_reg - 16'h1;
        end
      end
    end
  end
endmodule : ssl_logger
`default_nettype wire

/* File: bench/ssl_link_monitor.sv */
// Concurrent checks on the shared sensor link wire
`timescale 1ns/1ps
`default_nettype none
module ssl_link_monitor #(
  parameter int POWERUP_CYCLES = 2000,
  parameter int BIT_CYCLES = ssl_pkg::BIT_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic sensor_out,
  input wire logic sensor_oe,
  input wire logic logger_out,
  input wire logic logger_oe,
  input wire logic line
);
  localparam int BIT_CYC = BIT_CYCLES;
  logic prev_reg;
  int hold_reg;
  int up_reg;
  // Cycles since the sensor bit last changed, and since reset release up to POWERUP_CYCLES
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_reg <= 1'b0;
      hold_reg <= 0;
      up_reg <= 0;
    end else begin
      prev_reg <= sensor_out;
      hold_reg <= (sensor_out != prev_reg || !sensor_oe) ? 0 : hold_reg + 1;
      up_reg <= (up_reg < POWERUP_CYCLES) ? up_reg + 1 : up_reg;
    end
  end
  default clocking mon_cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence sens_start_s;
    $rose(sensor_oe) && sensor_out;
  endsequence
  sequence log_start_s;
    $rose(logger_oe) && logger_out;
  endsequence
  drive_wins_a: assert property (sensor_oe |-> line == sensor_out)
    else $error("line does not follow sensor drive");
  no_clash_a: assert property (!(sensor_oe && logger_oe))
    else $error("both ends drive the line");
  idle_low_a: assert property (!sensor_oe && !logger_oe |-> !line)
    else $error("released line not low");
  start_high_a: assert property ($rose(sensor_oe) |-> sensor_out)
    else $error("sensor frame without high start bit");
  start_hold_a: assert property (sens_start_s |=> (sensor_oe && sensor_out)[*8])
    else $error("sensor start bit cut short");
  bit_hold_a: assert property (sensor_oe && $past(sensor_oe) && $changed(sensor_out)
    |-> hold_reg >= BIT_CYC - 1)
    else $error("sensor bit shorter than one bit time");
  stop_low_a: assert property ($fell(sensor_oe)
    |-> !$past(sensor_out) && hold_reg >= BIT_CYC - 1)
    else $error("sensor released without full low stop bit");
  log_start_a: assert property (log_start_s |=> (logger_oe && logger_out)[*8])
    else $error("logger start bit cut short");
  log_stop_a: assert property ($fell(logger_oe) |-> !$past(logger_out))
    else $error("logger released without low stop bit");
  log_quiet_a: assert property (logger_oe |-> up_reg >= POWERUP_CYCLES)
    else $error("logger drove line during power-up");
endmodule : ssl_link_monitor
`default_nettype wire

/* File: bench/tb_sensor_sdi12_link.sv */
// Self-checking bench for both link ends
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_sdi12_link;
  localparam int PU = 2000;
  // Short bit time keeps the run brief
  localparam int BC = 16;
  localparam int FC = ssl_pkg::FRAME_BITS * ssl_pkg::BIT_CYCLES;
  typedef struct {logic [1:0] err; logic oor; logic neg; string resp;} ssl_row_s;
  logic clk, rst, supp, mvalid, mneg, moor, cvalid, mstart, ready, busy, cready, rxv, rxperr, q;
  logic [1:0] merr;
  logic [6:0] mdig [5];
  logic [6:0] cchar, rxc;
  int fail_count, checked, tries;
  logic [9:0] wq[$];
  logic [7:0] rq[$];
  ssl_row_s rows[5];
  ssl_if ssl_if_i ();
  ssl_sensor #(.POWERUP_CYCLES(PU), .BIT_CYCLES(BC), .SERIAL_LEN(2)) ssl_sensor_i (
    .core_clk_in(clk),
    .rst_in(rst), .link(ssl_if_i), .suppress_in(supp), .meas_valid_in(mvalid),
    .meas_digits_in(mdig), .meas_negative_in(mneg), .meas_error_in(merr),
    .meas_out_of_range_in(moor), .meas_start_out(mstart), .ready_out(ready), .busy_out(busy));
  ssl_logger #(.POWERUP_CYCLES(PU), .BIT_CYCLES(BC)) ssl_logger_i (.core_clk_in(clk),
    .rst_in(rst),
    .link(ssl_if_i), .cmd_valid_in(cvalid), .cmd_char_in(cchar), .cmd_ready_out(cready),
    .rx_valid_out(rxv), .rx_char_out(rxc), .rx_parity_err_out(rxperr));
  ssl_link_monitor #(.POWERUP_CYCLES(PU), .BIT_CYCLES(BC)) ssl_link_monitor_i (
    .core_clk_in(clk), .rst_in(rst),
    .sensor_out(ssl_if_i.sensor_out), .sensor_oe(ssl_if_i.sensor_oe),
    .logger_out(ssl_if_i.logger_out), .logger_oe(ssl_if_i.logger_oe), .line(ssl_if_i.line));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : chk_bit
  task automatic chk_char(input logic [6:0] got, input logic [6:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk_char
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  task automatic hang(input string what);
    fail_count++;
    $display("[FAIL] %0t timeout waiting for %s", $time, what);
    complete_run();
  endtask : hang
  // Decode sensor frames straight off the wire
  initial begin : wire_rx
    logic [9:0] f;
    forever begin
      @(posedge clk);
      if (ssl_if_i.sensor_oe === 1'b1 && ssl_if_i.line === 1'b1) begin
        repeat (BC / 2) @(posedge clk);
        for (int b = 0; b < 10; b++) begin
          f[b] = ~ssl_if_i.line;
          if (b < 9) repeat (BC) @(posedge clk);
        end
        wq.push_back(f);
      end
    end
  end
  always @(posedge clk) begin
    if (rxv === 1'b1) rq.push_back({rxperr, rxc});
  end
  task automatic send_cmd(input string s);
    int n;
    for (int i = 0; i < s.len(); i++) begin
      n = 0;
      @(posedge clk);
      while (cready !== 1'b1 && n < 2 * FC) begin
        @(posedge clk);
        n++;
      end
      if (cready !== 1'b1) hang("command ready");
      cvalid <= 1'b1;
      cchar <= s[i][6:0];
      @(posedge clk);
      cvalid <= 1'b0;
    end
  endtask : send_cmd
  task automatic give_meas(input ssl_row_s r);
    int n;
    n = 0;
    while (mstart !== 1'b1 && n < 4 * FC) begin
      @(posedge clk);
      n++;
    end
    chk_bit(mstart, 1'b1, "measurement start");
    if (mstart !== 1'b1) hang("measurement start");
    mvalid <= 1'b1;
    merr <= r.err;
    moor <= r.oor;
    mneg <= r.neg;
    @(posedge clk);
    mvalid <= 1'b0;
  endtask : give_meas
  task automatic expect_resp(input string s, input bit via_rx);
    int n;
    n = 0;
    while (wq.size() < s.len() && n < (s.len() + 2) * FC) begin
      @(posedge clk);
      n++;
    end
    if (wq.size() < s.len()) hang("response");
    repeat (BC) @(posedge clk);
    for (int i = 0; i < s.len(); i++) begin
      chk_bit(wq[i][0], 1'b0, "start bit");
      chk_char(wq[i][7:1], s[i][6:0], "wire char");
      chk_bit(^wq[i][8:1], 1'b0, "even parity");
      chk_bit(wq[i][9], 1'b1, "stop bit");
      if (via_rx) chk_char(rq[i][6:0], s[i][6:0], "logger char");
      if (via_rx) chk_bit(rq[i][7], 1'b0, "logger parity flag");
    end
    chk_bit(ssl_if_i.line, 1'b0, "idle line");
    chk_bit(busy, 1'b0, "line released");
    wq.delete();
    rq.delete();
  endtask : expect_resp
  initial begin
    rst = 1'b1;
    supp = 1'b0;
    mvalid = 1'b0;
    mneg = 1'b0;
    moor = 1'b0;
    merr = 2'h0;
    cvalid = 1'b0;
    cchar = 7'h00;
    fail_count = 0;
    checked = 0;
    mdig = '{7'h31, 7'h32, 7'h33, 7'h32, 7'h31};
    rows[0] = '{ssl_pkg::ERR_CAL, 1'b0, 1'b0, "0-09992\015\012"};
    rows[1] = '{ssl_pkg::ERR_VOLT, 1'b0, 1'b1, "0-09991\015\012"};
    rows[2] = '{ssl_pkg::ERR_FUNC, 1'b0, 1'b0, "0-09999\015\012"};
    rows[3] = '{ssl_pkg::ERR_NONE, 1'b0, 1'b0, "0+12321\015\012"};
    rows[4] = '{ssl_pkg::ERR_NONE, 1'b0, 1'b1, "0-12321\015\012"};
    repeat (10) @(posedge clk);
    chk_bit(busy, 1'b0, "busy in reset");
    chk_bit(cready, 1'b0, "command ready in reset");
    rst <= 1'b0;
    give_meas('{ssl_pkg::ERR_FUNC, 1'b1, 1'b0, ""});
    expect_resp("0-09990\015\012", 1'b0);
    tries = 0;
    while (ready !== 1'b1 && tries < PU) begin
      @(posedge clk);
      tries++;
    end
    chk_bit(ready, 1'b1, "listening after startup");
    $display("test startup done");
    send_cmd("0I!");
    expect_resp("013AAAAAAAABBBBBB100XX\015\012", 1'b1);
    $display("test identify done");
    send_cmd("?I!");
    expect_resp("013AAAAAAAABBBBBB100XX\015\012", 1'b1);
    $display("test wildcard done");
    foreach (rows[k]) begin
      send_cmd("0M!");
      give_meas(rows[k]);
      expect_resp(rows[k].resp, 1'b1);
      $display("test measure row %0d done", k);
    end
    send_cmd("0R3!");
    send_cmd("1I!");
    q = 1'b0;
    repeat (2 * FC) begin
      @(posedge clk);
      if (mstart === 1'b1 || busy === 1'b1) q = 1'b1;
    end
    chk_bit(q, 1'b0, "continuous command ignored");
    $display("test continuous done");
    rst <= 1'b1;
    supp <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    q = 1'b0;
    repeat (PU - 2) begin
      @(posedge clk);
      if (mstart === 1'b1 || busy === 1'b1 || ready === 1'b1 || cready === 1'b1) q = 1'b1;
    end
    chk_bit(q, 1'b0, "quiet suppressed power-up");
    repeat (4) @(posedge clk);
    chk_bit(ready, 1'b1, "ready after power-up");
    $display("test suppressed done");
    complete_run();
  end
endmodule : tb_sensor_sdi12_link
`default_nettype wire
